// File: design/clock_prescaler_defines.vh
// Constants for the clock prescaler and sleep controller
// Assumes inclusion by the design files and the bench alike
`ifndef CLOCK_PRESCALER_DEFINES_VH
`define CLOCK_PRESCALER_DEFINES_VH

// Register byte addresses on the Avalon-MM slave
`define ADDR_PRESCALE        4'h0
`define ADDR_SLEEP           4'h4
`define ADDR_STATUS          4'h8
`define ADDR_W               4

// Prescale control register fields
`define UNLOCK_BIT           7
`define DIVSEL_MSB           3
`define DIVSEL_RESET_FAST    4'h0
`define DIVSEL_RESET_DIV8    4'h3
`define DIVSEL_MAX           4'h8
`define UNLOCK_WINDOW        3'h4

// Sleep mode control register fields
`define SLEEP_EN_BIT         0
`define SMODE_LSB            1
`define SMODE_MSB            3
`define SMODE_IDLE           3'h0
`define SMODE_ADCNR          3'h1
`define SMODE_PDOWN          3'h2
`define SMODE_STANDBY        3'h6

// Wake timing
`define WAKE_HALT_CYCLES     4'h4
`define STANDBY_WAKE_CYCLES  16'h0006

// Wake source bit positions
`define WK_ADC               0
`define WK_EXTINT_EDGE       1
`define WK_EXTLEVEL          2
`define WK_TIMER             3
`define WK_SPM_EE            4
`define WK_PSC               5
`define WK_OTHER             6
`define WK_WIDTH             7

`endif

// File: design/clock_prescaler_sleep_ctrl.v
// Clock prescaler control and sleep controller with Avalon-MM registers
// Assumes a CPU sleep strobe, wake sources in the clk_sys domain, fuses
// stable after reset
`timescale 1ns/1ps
`include "clock_prescaler_defines.vh"

// Contract
// - Divide I/O, ADC, CPU, flash clocks by selected factor
// - Division change produces no glitch nor faster intermediate clock
// - New rate active within old period plus one to two new
// - Unlock bit updates only when other bits are written zero
// - Unlock clears four cycles after set or on divider write
// - Rewriting unlock inside window neither restarts nor clears it
// - Select values zero to eight give factors 1 to 256
// - Reset loads 0000 or 0011 from divide-by-eight fuse
// - Sleep entered only on sleep instruction with enable set
// - Mode codes: 000 idle, 001 ADC, 010 down, 110 standby
// - Interrupt wake halts CPU four cycles beyond start-up
// - Reset during sleep wakes and restarts from reset vector
// - Idle stops CPU and flash clocks; any interrupt wakes
// - Idle or ADC mode with ADC enabled starts conversion
// - ADC mode halts I/O, CPU, flash clocks; ADC runs
// - ADC mode wakes only on listed sources
// - Power-down stops oscillator and all generated clocks
// - Power-down wakes on level interrupt or power stage only
// - Power-down wake waits start-up delay from clock fuses
// - Standby as power-down with oscillator on, wakes on level interrupt only, six-cycle wake
module clock_prescaler_sleep_ctrl
#(
  parameter STARTUP_CYCLES = 16'h0400
)
(
  input  wire                  clk_sys,
  input  wire                  reset,
  input  wire [`ADDR_W-1:0]    address,
  input  wire                  read,
  input  wire                  write,
  input  wire [31:0]           writedata,
  output reg  [31:0]           readdata,
  output reg                   waitrequest,
  input  wire                  divide_by_eight_fuse,
  input  wire [3:0]            clock_source_fuses,
  input  wire                  sleep_instr,
  input  wire                  adc_enabled,
  input  wire [`WK_WIDTH-1:0]  wake_sources,
  output reg                   clk_cpu_en,
  output reg                   clk_flash_en,
  output reg                   clk_io_en,
  output reg                   clk_adc_en,
  output reg                   osc_en,
  output reg                   adc_start,
  output reg                   cpu_halt,
  output reg                   asleep
);

  localparam ST_RUN   = 4'b0001;
  localparam ST_SLEEP = 4'b0010;
  localparam ST_START = 4'b0100;
  localparam ST_HALT  = 4'b1000;

  reg  [3:0]  div_sel_reg;
  reg         unlock_reg;
  reg  [2:0]  unlock_cnt_reg;
  reg         div_load_reg;
  reg  [2:0]  smode_reg;
  reg         sleep_en_reg;
  reg  [3:0]  state_reg;
  reg  [2:0]  cur_mode_reg;
  reg  [15:0] wait_cnt_reg;
  reg         fuse_taken_reg;
  wire        tick;
  wire [3:0]  div_active;

  wire wr_acc = write & ~waitrequest;
  wire rd_acc = read & ~waitrequest;
  wire wr_pre = wr_acc && (address == `ADDR_PRESCALE);
  wire wr_slp = wr_acc && (address == `ADDR_SLEEP);
  wire only_unlock = writedata[`UNLOCK_BIT] && (writedata[6:0] == 7'h00);

  // Wake filter per sleep mode
  function wake_allowed;
    input [2:0]           mode;
    input [`WK_WIDTH-1:0] src;
    begin
      case (mode)
        `SMODE_IDLE:    wake_allowed = |src;
        `SMODE_ADCNR:   wake_allowed = src[`WK_ADC] | src[`WK_TIMER]
                                       | src[`WK_SPM_EE]
                                       | src[`WK_EXTLEVEL];
        `SMODE_PDOWN:   wake_allowed = src[`WK_EXTLEVEL] | src[`WK_PSC];
        `SMODE_STANDBY: wake_allowed = src[`WK_EXTLEVEL];
        default:        wake_allowed = 1'b0;
      endcase
    end
  endfunction

  function mode_valid;
    input [2:0] mode;
    begin
      mode_valid = (mode == `SMODE_IDLE) || (mode == `SMODE_ADCNR)
                   || (mode == `SMODE_PDOWN) || (mode == `SMODE_STANDBY);
    end
  endfunction

  ripple_prescaler
  #(
    .CNT_W (8)
  )
  u_prescaler
  (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .div_sel    (div_sel_reg),
    .div_load   (div_load_reg),
    .tick       (tick),
    .div_active (div_active)
  );

  // Bus slave: one wait state, then answer
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end
    else
    begin
      waitrequest <= ~((read | write) & waitrequest);
      if ((read & waitrequest))
      begin
        case (address)
          // Bits six to four read zero
          `ADDR_PRESCALE: readdata <= {24'h00_0000, unlock_reg, 3'b000,
                                       div_sel_reg};
          `ADDR_SLEEP:    readdata <= {28'h000_0000, smode_reg,
                                       sleep_en_reg};
          `ADDR_STATUS:   readdata <= {20'h0_0000, state_reg,
                                       div_active, 1'b0, cur_mode_reg};
          default:        readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Prescale control register
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      div_sel_reg    <= `DIVSEL_RESET_FAST;
      unlock_reg     <= 1'b0;
      unlock_cnt_reg <= 3'h0;
      div_load_reg   <= 1'b0;
      fuse_taken_reg <= 1'b0;
    end
    else
    begin
      div_load_reg <= 1'b0;
      if (!fuse_taken_reg)
      begin
        fuse_taken_reg <= 1'b1;
        div_sel_reg    <= divide_by_eight_fuse ? `DIVSEL_RESET_DIV8
                                               : `DIVSEL_RESET_FAST;
        div_load_reg   <= 1'b1;
      end
      else if (wr_pre && !writedata[`UNLOCK_BIT] && unlock_reg)
      begin
        unlock_reg <= 1'b0;
        if (writedata[`DIVSEL_MSB:0] <= `DIVSEL_MAX)
        begin
          div_sel_reg  <= writedata[`DIVSEL_MSB:0];
          div_load_reg <= 1'b1;
        end
      end
      // Unlock only with other bits zero
      else if (wr_pre && only_unlock && !unlock_reg)
      begin
        unlock_reg     <= 1'b1;
        unlock_cnt_reg <= `UNLOCK_WINDOW;
      end
      else if (unlock_reg)
      begin
        unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
        if (unlock_cnt_reg == 3'h1)
          unlock_reg <= 1'b0;
      end
    end
  end

  // Sleep mode control register
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      smode_reg    <= `SMODE_IDLE;
      sleep_en_reg <= 1'b0;
    end
    else if (wr_slp)
    begin
      smode_reg    <= writedata[`SMODE_MSB:`SMODE_LSB];
      sleep_en_reg <= writedata[`SLEEP_EN_BIT];
    end
  end

  // Sleep state machine
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_reg    <= ST_RUN;
      cur_mode_reg <= `SMODE_IDLE;
      wait_cnt_reg <= 16'h0000;
      adc_start    <= 1'b0;
    end
    else
    begin
      adc_start <= 1'b0;
      case (state_reg)
        ST_RUN:
        begin
          if (sleep_instr && sleep_en_reg && mode_valid(smode_reg))
          begin
            state_reg    <= ST_SLEEP;
            cur_mode_reg <= smode_reg;
            adc_start    <= adc_enabled && ((smode_reg == `SMODE_IDLE)
                            || (smode_reg == `SMODE_ADCNR));
          end
        end
        ST_SLEEP:
        begin
          if (wake_allowed(cur_mode_reg, wake_sources))
          begin
            state_reg <= ST_START;
            if (cur_mode_reg == `SMODE_PDOWN)
              wait_cnt_reg <= (clock_source_fuses == 4'h0)
                              ? `STANDBY_WAKE_CYCLES
                              : STARTUP_CYCLES[15:0];
            else if (cur_mode_reg == `SMODE_STANDBY)
              wait_cnt_reg <= `STANDBY_WAKE_CYCLES;
            else
              wait_cnt_reg <= 16'h0001;
          end
        end
        ST_START:
        begin
          wait_cnt_reg <= wait_cnt_reg - 16'h0001;
          if (wait_cnt_reg == 16'h0001)
          begin
            state_reg    <= ST_HALT;
            wait_cnt_reg <= {12'h000, `WAKE_HALT_CYCLES};
          end
        end
        ST_HALT:
        begin
          wait_cnt_reg <= wait_cnt_reg - 16'h0001;
          if (wait_cnt_reg == 16'h0001)
            state_reg <= ST_RUN;
        end
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

  // Clock domain gating
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      clk_cpu_en   <= 1'b0;
      clk_flash_en <= 1'b0;
      clk_io_en    <= 1'b0;
      clk_adc_en   <= 1'b0;
      osc_en       <= 1'b1;
      cpu_halt     <= 1'b0;
      asleep       <= 1'b0;
    end
    else
    begin
      asleep   <= (state_reg == ST_SLEEP);
      cpu_halt <= (state_reg != ST_RUN);
      if (state_reg == ST_RUN)
      begin
        clk_cpu_en   <= tick;
        clk_flash_en <= tick;
        clk_io_en    <= tick;
        clk_adc_en   <= tick;
        osc_en       <= 1'b1;
      end
      else
      begin
        clk_cpu_en   <= 1'b0;
        clk_flash_en <= 1'b0;
        clk_io_en    <= tick && (state_reg == ST_SLEEP)
                        && (cur_mode_reg == `SMODE_IDLE);
        clk_adc_en   <= tick && (state_reg == ST_SLEEP)
                        && ((cur_mode_reg == `SMODE_IDLE)
                        || (cur_mode_reg == `SMODE_ADCNR));
        osc_en       <= !((state_reg == ST_SLEEP)
                        && (cur_mode_reg == `SMODE_PDOWN));
      end
    end
  end

endmodule // clock_prescaler_sleep_ctrl

// File: design/ripple_prescaler.v
// Glitch-free power-of-two clock enable divider
// Assumes clk_sys is the undivided source and div_sel is stable per request
`timescale 1ns/1ps
`include "clock_prescaler_defines.vh"

module ripple_prescaler
#(
  parameter CNT_W = 8
)
(
  input  wire             clk_sys,
  input  wire             reset,
  input  wire [3:0]       div_sel,
  input  wire             div_load,
  output reg              tick,
  output reg  [3:0]       div_active
);

  reg [CNT_W-1:0] count_reg;
  reg [3:0]       pending_reg;
  reg             pend_flag_reg;

  function [CNT_W-1:0] div_mask;
    input [3:0] sel;
    begin
      div_mask = (({{(CNT_W-1){1'b0}}, 1'b1} << sel) - 1'b1);
    end
  endfunction

  wire [CNT_W-1:0] mask_old = div_mask(div_active);
  wire             old_edge = ((count_reg & mask_old) == mask_old);

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      count_reg     <= {CNT_W{1'b0}};
      tick          <= 1'b0;
      div_active    <= 4'h0;
      pending_reg   <= 4'h0;
      pend_flag_reg <= 1'b0;
    end
    else
    begin
      tick      <= old_edge;
      count_reg <= old_edge ? {CNT_W{1'b0}} : count_reg + 1'b1;
      if (div_load)
      begin
        pending_reg   <= div_sel;
        pend_flag_reg <= 1'b1;
      end
      else if (pend_flag_reg && old_edge)
      begin
        div_active    <= pending_reg;
        pend_flag_reg <= 1'b0;
      end
    end
  end

endmodule // ripple_prescaler

// File: test/clock_prescaler_chk.sv
// Port assertions for the prescaler and sleep controller
// Assumes binding onto clock_prescaler_sleep_ctrl
`timescale 1ns/1ps
module clock_prescaler_chk (
  input wire clk_sys,
  input wire reset,
  input wire read,
  input wire write,
  input wire waitrequest,
  input wire sleep_instr,
  input wire clk_cpu_en,
  input wire clk_flash_en,
  input wire clk_io_en,
  input wire clk_adc_en,
  input wire osc_en,
  input wire adc_start,
  input wire cpu_halt,
  input wire asleep
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence seq_req;
    (read || write) && waitrequest;
  endsequence
  sequence seq_halt4;
    cpu_halt [*4];
  endsequence
  chk_bus_answer: assert property (seq_req |-> ##[1:2] !waitrequest)
    else $error("waitrequest never dropped");
  chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  chk_idle_wait: assert property (!read && !write |-> waitrequest)
    else $error("waitrequest low while idle");
  chk_cpu_flash: assert property (clk_cpu_en == clk_flash_en)
    else $error("cpu and flash enables differ");
  chk_io_adc: assert property (clk_io_en |-> clk_adc_en)
    else $error("io runs without adc clock");
  chk_halt_gate: assert property (cpu_halt ##1 cpu_halt |-> !clk_cpu_en)
    else $error("cpu clock while halted");
  chk_osc_sleep: assert property (!osc_en |-> cpu_halt)
    else $error("oscillator off while running");
  chk_entry_cause: assert property ($rose(asleep) |->
    $past(sleep_instr) || $past(sleep_instr, 2))
    else $error("sleep without instruction");
  chk_adc_kick: assert property (adc_start |-> ##[0:2] asleep)
    else $error("adc start outside sleep entry");
  chk_wake_halt: assert property ($fell(asleep) |-> seq_halt4)
    else $error("halt shorter than four cycles");
endmodule // clock_prescaler_chk

bind clock_prescaler_sleep_ctrl clock_prescaler_chk chk_u (
  .clk_sys(clk_sys), .reset(reset), .read(read), .write(write),
  .waitrequest(waitrequest), .sleep_instr(sleep_instr),
  .clk_cpu_en(clk_cpu_en), .clk_flash_en(clk_flash_en),
  .clk_io_en(clk_io_en), .clk_adc_en(clk_adc_en), .osc_en(osc_en),
  .adc_start(adc_start), .cpu_halt(cpu_halt), .asleep(asleep));

// File: test/test_clock_prescaler_sleep_ctrl.sv
// Self-checking bench for the prescaler and sleep controller
// Assumes the defines header is on the include path
`timescale 1ns/1ps
`include "clock_prescaler_defines.vh"
module test_clock_prescaler_sleep_ctrl;
  reg         clk_sys, reset, read, write, sleep_instr, adc_enabled;
  reg         divide_by_eight_fuse, kick;
  reg  [3:0]  address, clock_source_fuses;
  reg  [31:0] writedata, q;
  reg  [6:0]  wake_sources;
  reg  [2:0]  md;
  wire [31:0] readdata;
  wire        waitrequest, clk_cpu_en, clk_flash_en, clk_io_en;
  wire        clk_adc_en, osc_en, adc_start, cpu_halt, asleep;
  integer     failures, compares, d, p, n, m, i, ci, cio, cad;

  clock_prescaler_sleep_ctrl #(.STARTUP_CYCLES(16'h0008)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .divide_by_eight_fuse(divide_by_eight_fuse),
    .clock_source_fuses(clock_source_fuses), .sleep_instr(sleep_instr),
    .adc_enabled(adc_enabled), .wake_sources(wake_sources),
    .clk_cpu_en(clk_cpu_en), .clk_flash_en(clk_flash_en),
    .clk_io_en(clk_io_en), .clk_adc_en(clk_adc_en), .osc_en(osc_en),
    .adc_start(adc_start), .cpu_halt(cpu_halt), .asleep(asleep));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (adc_start === 1'b1)
      kick <= 1'b1;

  task check(input [31:0] seen, input [31:0] exp, input string nm);
    compares = compares + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("FAIL %0s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task bus(input w, input [3:0] a, input [31:0] dt);
    integer k;
    @(posedge clk_sys);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= dt;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k = k + 1;
    end
    while (waitrequest !== 1'b0 && k < 40);
    if (k == 40)
      failures = failures + 1;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task period;
    integer k;
    for (k = 0; k < 5; k = k + 1)
    begin
      p = 0;
      do
      begin
        @(posedge clk_sys);
        p = p + 1;
      end
      while (clk_cpu_en !== 1'b1 && p < 600);
    end
  endtask

  task enter(input [2:0] mo, input en);
    bus(1, `ADDR_SLEEP, {28'h0, mo, en});
    kick = 1'b0;
    @(posedge clk_sys);
    sleep_instr <= 1'b1;
    @(posedge clk_sys);
    sleep_instr <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task count8;
    ci = 0;
    cio = 0;
    cad = 0;
    repeat (8)
    begin
      @(posedge clk_sys);
      ci = ci + clk_cpu_en;
      cio = cio + clk_io_en;
      cad = cad + clk_adc_en;
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures = failures + 1;
    tally_and_finish;
  end

  initial
  begin
    failures = 0;
    compares = 0;
    {read, write, sleep_instr, wake_sources, kick} = 0;
    address = 4'h0;
    writedata = 32'h0;
    reset = 1'b1;
    divide_by_eight_fuse = 1'b1;
    clock_source_fuses = 4'h1;
    adc_enabled = 1'b1;
    void'($urandom(32'h3f32));
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    bus(0, `ADDR_PRESCALE, 0);
    check(q, 32'h0000_0003, "div reset");
    bus(0, 4'hc, 0);
    check(q, 32'h0000_0000, "unmapped");
    // Unlock write alone, divider next, no interrupts
    for (i = 0; i < 4; i = i + 1)
    begin
      d = (i < 2) ? 8 * (1 - i) : $urandom_range(8);
      bus(1, `ADDR_PRESCALE, 32'h0000_0080);
      bus(1, `ADDR_PRESCALE, d);
      period;
      check(p, 1 << d, "div period");
    end
    bus(1, `ADDR_PRESCALE, 32'h0000_0080);
    bus(0, `ADDR_PRESCALE, 0);
    check(q[7], 1'b1, "unlock set");
    bus(1, `ADDR_PRESCALE, 32'h0000_0080);
    bus(1, `ADDR_PRESCALE, 32'h0000_0075);
    bus(0, `ADDR_PRESCALE, 0);
    check(q, 32'h0000_0005, "high bits");
    bus(1, `ADDR_PRESCALE, 32'h0000_0081);
    bus(1, `ADDR_PRESCALE, 32'h0000_0002);
    bus(0, `ADDR_PRESCALE, 0);
    check(q, 32'h0000_0005, "bad unlock");
    bus(1, `ADDR_PRESCALE, 32'h0000_0080);
    repeat (3) @(posedge clk_sys);
    bus(1, `ADDR_PRESCALE, 32'h0000_0001);
    bus(0, `ADDR_PRESCALE, 0);
    check(q, 32'h0000_0005, "timeout");
    bus(1, `ADDR_PRESCALE, 32'h0000_0080);
    bus(1, `ADDR_PRESCALE, 32'h0000_0080);
    bus(1, `ADDR_PRESCALE, 32'h0000_0001);
    bus(0, `ADDR_PRESCALE, 0);
    check(q, 32'h0000_0005, "rewrite");
    bus(1, `ADDR_PRESCALE, 32'h0000_0080);
    bus(1, `ADDR_PRESCALE, 32'h0000_0009);
    bus(1, `ADDR_PRESCALE, 32'h0000_0080);
    bus(1, `ADDR_PRESCALE, 32'h0000_0000);
    bus(0, `ADDR_PRESCALE, 0);
    check(q, 32'h0000_0000, "reserved div");
    enter(`SMODE_IDLE, 1'b0);
    check(asleep, 1'b0, "no enable");
    enter(3'h3, 1'b1);
    check(asleep, 1'b0, "bad mode");
    for (i = 0; i < 4; i = i + 1)
    begin
      md = (i == 0) ? `SMODE_IDLE : (i == 1) ? `SMODE_ADCNR :
           (i == 2) ? `SMODE_PDOWN : `SMODE_STANDBY;
      enter(md, 1'b1);
      check(asleep, 1'b1, "asleep");
      check(kick, md < 2, "adc start");
      count8;
      check(ci, 0, "cpu clock");
      check(cio, (md == 0) ? 8 : 0, "io clock");
      check(cad, (md < 2) ? 8 : 0, "adc clock");
      check(osc_en, md != 2, "osc");
      if (md != 0)
      begin
        wake_sources[(md == 1) ? 1 : (md == 2) ? 3 : 0] <= 1'b1;
        repeat (12) @(posedge clk_sys);
        check(asleep, 1'b1, "bad wake");
        wake_sources <= 7'h00;
      end
      wake_sources[`WK_EXTLEVEL] <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clk_sys);
        n = n + 1;
      end
      while (cpu_halt !== 1'b0 && n < 60);
      wake_sources <= 7'h00;
      m = (md < 2) ? 1 : (md == 6) ? 6 : 8;
      check(n >= m + 4 && n <= m + 8, 1'b1, "wake time");
    end
    enter(`SMODE_PDOWN, 1'b1);
    divide_by_eight_fuse <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    check(asleep, 1'b0, "reset wake");
    bus(0, `ADDR_PRESCALE, 0);
    check(q, 32'h0000_0000, "fuse off");
    tally_and_finish;
  end
endmodule // test_clock_prescaler_sleep_ctrl
